/* File: verilog/lpcs_synth.sv */
// line-locked pixel clock synthesiser with AXI4-Lite registers
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module lpcs_synth
   import lpcs_pkg::*;
#(
   parameter int LINE_W     = 12,
   parameter int GAIN_SHIFT = 12
)
(
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   input  wire logic        reference_clock_in,
   input  wire logic        horizontal_sync_in,
   output logic             synth_clock_out,
   output logic             locked_out,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   localparam logic [36:0] STEP_MAX = 37'((38'h1 << STEP_W) - 38'h1);

   logic              aw_full_q;
   logic              w_full_q;
   logic [7:0]        aw_addr_q;
   logic [31:0]       w_data_q;
   logic              w_lane0_q;
   logic              wr_fire;
   logic              wr_en;
   logic              wr_hit;
   logic              nom_wr;
   logic [32:0]       nom_d;
   logic [31:0]       rd_data;
   logic              rd_hit;

   logic [LINE_W-1:0] line_length_divider;
   logic [32:0]       nominal_phase_step;
   logic [32:0]       phase_step;
   logic [1:0]        vco_multiplier_code;
   logic [1:0]        output_clock_divider;
   logic              lock_en_q;
   logic              locked_q;

   logic              ref_prev_q;
   logic              hs_prev_q;
   logic              ref_edge;
   logic              hs_edge;
   logic [36:0]       acc_q;
   logic [36:0]       credit;
   logic              dto_tick;
   logic              cycle_tick;
   logic [15:0]       line_count_q;
   logic [15:0]       measured_q;
   logic signed [39:0] line_err;
   logic signed [39:0] step_sum;
   logic [32:0]       step_trim;

   // ==========================================================
   // write channels, taken in either order
   assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_full_q && !s_axi_bvalid;
   assign wr_fire       = aw_full_q && w_full_q && !s_axi_bvalid;
   assign wr_en         = wr_fire && w_lane0_q;

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h0000_0000;
         w_lane0_q <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         else if (wr_fire)
         begin
            aw_full_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_full_q  <= 1'b1;
            w_data_q  <= s_axi_wdata;
            w_lane0_q <= s_axi_wstrb[0];
         end
         else if (wr_fire)
         begin
            w_full_q <= 1'b0;
         end
      end
   end

   always_comb
   begin
      wr_hit = 1'b1;
      nom_wr = 1'b0;
      nom_d  = nominal_phase_step;
      if (aw_addr_q == OFF_NOM_0)
      begin
         nom_wr     = 1'b1;
         nom_d[7:0] = w_data_q[7:0];
      end
      else if (aw_addr_q == OFF_NOM_1)
      begin
         nom_wr      = 1'b1;
         nom_d[15:8] = w_data_q[7:0];
      end
      else if (aw_addr_q == OFF_NOM_2)
      begin
         nom_wr       = 1'b1;
         nom_d[23:16] = w_data_q[7:0];
      end
      else if (aw_addr_q == OFF_NOM_3)
      begin
         nom_wr       = 1'b1;
         nom_d[31:24] = w_data_q[7:0];
      end
      else if (aw_addr_q == OFF_NOM_4)
      begin
         nom_wr    = 1'b1;
         nom_d[32] = w_data_q[0];
      end
      else if (aw_addr_q != OFF_LINE_LO && aw_addr_q != OFF_LINE_HI && aw_addr_q != OFF_VCO_CODE
               && aw_addr_q != OFF_OUT_CODE && aw_addr_q != OFF_CTRL)
      begin
         wr_hit = 1'b0;
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // settings written by software
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         line_length_divider  <= LINE_LEN_RST[LINE_W-1:0];
         vco_multiplier_code  <= VCO_CODE_RST;
         output_clock_divider <= OUT_CODE_RST;
         lock_en_q            <= 1'b0;
      end
      else if (wr_en)
      begin
         if (aw_addr_q == OFF_LINE_LO)
         begin
            line_length_divider[7:0] <= w_data_q[7:0];
         end
         else if (aw_addr_q == OFF_LINE_HI)
         begin
            line_length_divider[LINE_W-1:8] <= w_data_q[LINE_W-9:0];
         end
         else if (aw_addr_q == OFF_VCO_CODE)
         begin
            vco_multiplier_code <= w_data_q[1:0];
         end
         else if (aw_addr_q == OFF_OUT_CODE)
         begin
            output_clock_divider <= w_data_q[1:0];
         end
         else if (aw_addr_q == OFF_CTRL)
         begin
            lock_en_q <= w_data_q[CTRL_LOCK_EN];
         end
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         nominal_phase_step <= NOM_STEP_RST;
      end
      else if (wr_en && nom_wr)
      begin
         nominal_phase_step <= nom_d;
      end
   end

   // ==========================================================
   // read channel, answer one cycle after the address
   assign s_axi_arready = !s_axi_rvalid;

   always_comb
   begin
      rd_hit  = 1'b1;
      rd_data = 32'h0000_0000;
      if (s_axi_araddr == OFF_LINE_LO)
      begin
         rd_data[7:0] = line_length_divider[7:0];
      end
      else if (s_axi_araddr == OFF_LINE_HI)
      begin
         rd_data[LINE_W-9:0] = line_length_divider[LINE_W-1:8];
      end
      else if (s_axi_araddr == OFF_NOM_0)
      begin
         rd_data[7:0] = nominal_phase_step[7:0];
      end
      else if (s_axi_araddr == OFF_NOM_1)
      begin
         rd_data[7:0] = nominal_phase_step[15:8];
      end
      else if (s_axi_araddr == OFF_NOM_2)
      begin
         rd_data[7:0] = nominal_phase_step[23:16];
      end
      else if (s_axi_araddr == OFF_NOM_3)
      begin
         rd_data[7:0] = nominal_phase_step[31:24];
      end
      else if (s_axi_araddr == OFF_NOM_4)
      begin
         rd_data[0] = nominal_phase_step[32];
      end
      else if (s_axi_araddr == OFF_VCO_CODE)
      begin
         rd_data[1:0] = vco_multiplier_code;
      end
      else if (s_axi_araddr == OFF_OUT_CODE)
      begin
         rd_data[1:0] = output_clock_divider;
      end
      else if (s_axi_araddr == OFF_CTRL)
      begin
         rd_data[CTRL_LOCK_EN] = lock_en_q;
      end
      else if (s_axi_araddr == OFF_STATUS)
      begin
         rd_data[STAT_LOCKED] = locked_q;
      end
      else if (s_axi_araddr == OFF_STEP_LO)
      begin
         rd_data = phase_step[31:0];
      end
      else if (s_axi_araddr == OFF_STEP_HI)
      begin
         rd_data[0] = phase_step[32];
      end
      else if (s_axi_araddr == OFF_MEASURED)
      begin
         rd_data[15:0] = measured_q;
      end
      else
      begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_data;
         s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // VCO credit and phase oscillator
   assign ref_edge = reference_clock_in && !ref_prev_q;
   assign hs_edge  = horizontal_sync_in && !hs_prev_q;

   // each rising reference edge brings 2^code VCO periods
   // each VCO period is worth 32 in step units
   assign credit   = 37'h1 << (FRAC_W + VCO_SCALE_LOG + int'(vco_multiplier_code));
   // fraction weighted as integer times 2^-27
   assign dto_tick = (phase_step != 33'h0) && (acc_q >= {4'h0, phase_step});

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         ref_prev_q <= 1'b0;
         hs_prev_q  <= 1'b0;
         acc_q      <= 37'h0;
      end
      else
      begin
         ref_prev_q <= reference_clock_in;
         hs_prev_q  <= horizontal_sync_in;
         // one tick a cycle at most: reference must be slow against clock_in
         acc_q      <= acc_q + (ref_edge ? credit : 37'h0) - (dto_tick ? {4'h0, phase_step} : 37'h0);
      end
   end

   lpcs_out_div u_out_div
   (
      .clock_in        (clock_in),
      .rst_in          (rst_in),
      .tick_in         (dto_tick),
      .code_in         (output_clock_divider),
      .synth_clock_out (synth_clock_out),
      .cycle_tick_out  (cycle_tick)
   );

   // ==========================================================
   // line lock loop
   assign line_err = 40'(signed'({24'h0, line_count_q})) - 40'(signed'({28'h0, 16'(line_length_divider)}));
   assign step_sum = $signed({7'h0, phase_step}) + (line_err <<< GAIN_SHIFT);
   // stay within the unsigned 33-bit range
   assign step_trim = (step_sum < 40'sh0) ? 33'h0 :
                      (step_sum > $signed({3'h0, STEP_MAX})) ? 33'h1_FFFF_FFFF : step_sum[32:0];

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         line_count_q <= 16'h0;
         measured_q   <= 16'h0;
      end
      else if (hs_edge)
      begin
         line_count_q <= cycle_tick ? 16'h1 : 16'h0;
         measured_q   <= line_count_q;
      end
      else if (cycle_tick && line_count_q != 16'hFFFF)
      begin
         line_count_q <= line_count_q + 16'h1;
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         phase_step <= NOM_STEP_RST;
         locked_q   <= 1'b0;
      end
      else if (wr_en && nom_wr)
      begin
         phase_step <= nom_d;
         locked_q   <= 1'b0;
      end
      // too many cycles per line: raise step
      else if (hs_edge && lock_en_q)
      begin
         phase_step <= step_trim;
         locked_q   <= (line_count_q == 16'(line_length_divider));
      end
      else if (!lock_en_q)
      begin
         locked_q <= 1'b0;
      end
   end

   assign locked_out = locked_q;

   // ==========================================================
   // checks
   // default after reset
   AST_NOM_RESET: assert property (@(posedge clock_in) disable iff (rst_in) $past(rst_in) |->
      nominal_phase_step == NOM_STEP_RST && phase_step == NOM_STEP_RST)
      else $error("nominal step not at default after reset");

   AST_STEP_LOAD: assert property (@(posedge clock_in) disable iff (rst_in)
      wr_en && nom_wr |=> phase_step == nominal_phase_step)
      else $error("working step not loaded from nominal");

   AST_NOM_TOP: assert property (@(posedge clock_in) disable iff (rst_in)
      wr_en && aw_addr_q == OFF_NOM_4 |=> nominal_phase_step[32] == $past(w_data_q[0])
      && nominal_phase_step[31:0] == $past(nominal_phase_step[31:0]))
      else $error("nominal top byte wrong");

   AST_LINE_HI: assert property (@(posedge clock_in) disable iff (rst_in)
      wr_en && aw_addr_q == OFF_LINE_HI |=> line_length_divider[LINE_W-1:8] == $past(w_data_q[LINE_W-9:0])
      && line_length_divider[7:0] == $past(line_length_divider[7:0]))
      else $error("line length upper bits wrong");

   AST_TICK_TAKE: assert property (@(posedge clock_in) disable iff (rst_in)
      dto_tick && !ref_edge |=> acc_q == $past(acc_q) - {4'h0, $past(phase_step)})
      else $error("oscillator tick did not take one step");

   AST_VCO_CREDIT: assert property (@(posedge clock_in) disable iff (rst_in)
      ref_edge && !dto_tick |=> acc_q == $past(acc_q) + (37'h1 << (32 + int'($past(vco_multiplier_code)))))
      else $error("VCO credit wrong");

   // match gives lock and keeps step
   AST_LOCK_MATCH: assert property (@(posedge clock_in) disable iff (rst_in)
      hs_edge && lock_en_q && !(wr_en && nom_wr) && line_count_q == 16'(line_length_divider)
      |=> locked_out && $stable(phase_step))
      else $error("matched line did not lock");

   AST_STEP_UP: assert property (@(posedge clock_in) disable iff (rst_in)
      hs_edge && lock_en_q && !(wr_en && nom_wr) && line_count_q > 16'(line_length_divider)
      && phase_step != 33'h1_FFFF_FFFF |=> phase_step > $past(phase_step))
      else $error("step not raised on long line");

   AST_BHOLD: assert property (@(posedge clock_in) disable iff (rst_in)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped before taken");

   COV_LOCK: cover property (@(posedge clock_in) disable iff (rst_in) $rose(locked_out));
   COV_NOM_WRITE: cover property (@(posedge clock_in) disable iff (rst_in) wr_en && nom_wr);
   COV_BAD_READ: cover property (@(posedge clock_in) disable iff (rst_in)
      s_axi_rvalid && s_axi_rresp == RESP_SLVERR);

endmodule // lpcs_synth

`default_nettype wire

/* File: inc/lpcs_pkg.sv */
// constants shared by the line-locked pixel clock synthesiser
`default_nettype none

package lpcs_pkg;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFF_LINE_LO    = 8'h00;
   localparam logic [7:0] OFF_LINE_HI    = 8'h04;
   localparam logic [7:0] OFF_NOM_0      = 8'h08;
   localparam logic [7:0] OFF_NOM_1      = 8'h0C;
   localparam logic [7:0] OFF_NOM_2      = 8'h10;
   localparam logic [7:0] OFF_NOM_3      = 8'h14;
   localparam logic [7:0] OFF_NOM_4      = 8'h18;
   localparam logic [7:0] OFF_VCO_CODE   = 8'h1C;
   localparam logic [7:0] OFF_OUT_CODE   = 8'h20;
   localparam logic [7:0] OFF_CTRL       = 8'h24;
   localparam logic [7:0] OFF_STATUS     = 8'h28;
   localparam logic [7:0] OFF_STEP_LO    = 8'h2C;
   localparam logic [7:0] OFF_STEP_HI    = 8'h30;
   localparam logic [7:0] OFF_MEASURED   = 8'h34;

   // ==========================================================
   // field widths, scales and positions
   localparam int          STEP_W        = 33;
   localparam int          FRAC_W        = 27;
   localparam int          INT_W         = 6;
   localparam int          CTRL_LOCK_EN  = 0;
   localparam int          STAT_LOCKED   = 0;
   localparam int          VCO_SCALE_LOG = 5;

   // ==========================================================
   // reset values
   localparam logic [32:0] NOM_STEP_RST  = 33'h0BA2E8A16;
   localparam logic [15:0] LINE_LEN_RST  = 16'h0520;
   localparam logic [1:0]  VCO_CODE_RST  = 2'h3;
   localparam logic [1:0]  OUT_CODE_RST  = 2'h1;

   // ==========================================================
   // bus answers
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage : lpcs_pkg

`default_nettype wire

/* File: verilog/lpcs_out_div.sv */
// output clock divider of the synthesiser
`timescale 1ns/1ps
`default_nettype none

module lpcs_out_div
   import lpcs_pkg::*;
(
   input  wire logic       clock_in,
   input  wire logic       rst_in,
   input  wire logic       tick_in,
   input  wire logic [1:0] code_in,
   output logic            synth_clock_out,
   output logic            cycle_tick_out
);

   logic [6:0] cnt_q;
   logic [6:0] cnt_d;
   logic [6:0] last_count;
   logic [6:0] half_count;
   logic       wrap;

   // ==========================================================
   // division by two to the code
   // log2 divider code
   assign last_count = 7'((8'h01 << code_in) - 8'h01);
   assign half_count = 7'((8'h01 << code_in) >> 1);
   assign wrap       = tick_in && (cnt_q >= last_count);

   always_comb
   begin
      cnt_d = cnt_q;
      if (wrap)
      begin
         cnt_d = 7'h00;
      end
      else if (tick_in)
      begin
         cnt_d = cnt_q + 7'h01;
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         cnt_q <= 7'h00;
      end
      else
      begin
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         synth_clock_out <= 1'b0;
         cycle_tick_out  <= 1'b0;
      end
      else
      begin
         // divide by one cannot toggle: pass the tick as a pulse
         synth_clock_out <= (code_in == 2'h0) ? tick_in : (cnt_d < half_count);
         cycle_tick_out  <= wrap;
      end
   end

   // ==========================================================
   // checks
   // one period per divided ticks
   AST_OUT_WRAP: assert property (@(posedge clock_in) disable iff (rst_in)
      cycle_tick_out |-> $past(tick_in) && ($past(cnt_q) >= $past(last_count)))
      else $error("output period not closed on last tick");

   COV_DIV8: cover property (@(posedge clock_in) disable iff (rst_in)
      code_in == 2'h3 && cycle_tick_out);

endmodule // lpcs_out_div

`default_nettype wire

/* File: bench/lpcs_hsync_src.sv */
// line sync source that feeds the synthesiser
`timescale 1ns/1ps
`default_nettype none

module lpcs_hsync_src
(
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   input  wire logic        enable_in,
   input  wire logic [15:0] period_in,
   output logic             horizontal_sync_out
);
   logic [15:0] count_q;

   // ==========================================================
   // line timer
   // a new period takes effect at once, on the line in progress
   always_ff @(posedge clock_in)
   begin
      if (rst_in || !enable_in || count_q >= period_in - 16'h0001)
         count_q <= 16'h0000;
      else
         count_q <= count_q + 16'h0001;
   end

   // pulse width of eight cycles, well inside any sane line
   always_ff @(posedge clock_in)
   begin
      horizontal_sync_out <= enable_in && !rst_in && (count_q < 16'h0008);
   end
endmodule // lpcs_hsync_src

`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench for the pixel clock synthesiser
`timescale 1ns/1ps
`default_nettype none

module tb_top
   import lpcs_pkg::*;
;
   typedef struct {logic [31:0] val; logic [31:0] msk; logic [1:0] resp;} lpcs_note_s;

   localparam int TIMEOUT_CYC = 60000;

   logic        clock_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        reference_clock_in = 1'b0;
   logic [3:0]  ref_cnt = 4'h0;
   wire  logic  horizontal_sync_in;
   wire  logic  synth_clock_out;
   wire  logic  locked_out;
   logic        hs_en = 1'b0;
   logic [15:0] hs_per = 16'h0200;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic        s_axi_awvalid = 1'b0;
   wire  logic  s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_wvalid = 1'b0;
   wire  logic  s_axi_wready;
   wire  logic [1:0] s_axi_bresp;
   wire  logic  s_axi_bvalid;
   logic        s_axi_bready = 1'b0;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic        s_axi_arvalid = 1'b0;
   wire  logic  s_axi_arready;
   wire  logic [31:0] s_axi_rdata;
   wire  logic [1:0] s_axi_rresp;
   wire  logic  s_axi_rvalid;
   logic        s_axi_rready = 1'b0;
   lpcs_note_s  rq[$];
   logic [1:0]  wq[$];
   lpcs_note_s  nt;
   logic [31:0] rd_last = 32'h0;
   logic        so_q = 1'b0;
   int          out_edges = 0;
   int          out_highs = 0;
   int          err_count = 0;
   int          n_checks = 0;
   int          cyc = 0;

   lpcs_synth dut_u (.clock_in(clock_in), .rst_in(rst_in), .reference_clock_in(reference_clock_in),
      .horizontal_sync_in(horizontal_sync_in), .synth_clock_out(synth_clock_out), .locked_out(locked_out),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   lpcs_hsync_src sync_u (.clock_in(clock_in), .rst_in(rst_in), .enable_in(hs_en), .period_in(hs_per),
      .horizontal_sync_out(horizontal_sync_in));

   // ==========================================================
   // clocks and watchdog
   initial
   begin
      forever #20 clock_in = !clock_in;
   end

   // reference period of 32 cycles keeps credit per edge within limits
   always @(posedge clock_in)
   begin
      ref_cnt <= ref_cnt + 4'h1;
      if (ref_cnt == 4'hF)
         reference_clock_in <= !reference_clock_in;
      cyc <= cyc + 1;
      if (cyc == TIMEOUT_CYC)
      begin
         err_count++;
         wrap_up();
      end
   end

   // ==========================================================
   // comparisons and monitors
   task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   // phase of the window may gain or lose one edge
   task automatic near(string nm, real e, int g);
      n_checks++;
      if (real'(g) - e > 1.5 || e - real'(g) > 1.5)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %0d seen %0d", nm, $rtoi(e + 0.5), g);
      end
   endtask

   // sampled mid-cycle, clear of the edge that updates the design
   always @(negedge clock_in)
   begin
      so_q <= synth_clock_out;
      if (synth_clock_out && !so_q)
         out_edges <= out_edges + 1;
      if (synth_clock_out)
         out_highs <= out_highs + 1;
      if (s_axi_bvalid && s_axi_bready)
         cmp("bresp", {30'h0, wq.pop_front()}, {30'h0, s_axi_bresp});
      if (s_axi_rvalid && s_axi_rready)
      begin
         nt = rq.pop_front();
         rd_last <= s_axi_rdata;
         cmp("rdata", nt.val & nt.msk, s_axi_rdata & nt.msk);
         cmp("rresp", {30'h0, nt.resp}, {30'h0, s_axi_rresp});
      end
   end

   // ==========================================================
   // bus master tasks
   task automatic wr(logic [7:0] a, logic [7:0] d, logic [1:0] r = RESP_OKAY);
      logic ta;
      logic tw;
      logic tbv;
      wq.push_back(r);
      @(posedge clock_in);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(negedge clock_in);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tbv = s_axi_bvalid;
         @(posedge clock_in);
         if (ta)
            s_axi_awvalid <= 1'b0;
         if (tw)
            s_axi_wvalid <= 1'b0;
      end while (!tbv);
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m = 32'hFFFFFFFF, logic [1:0] r = RESP_OKAY);
      logic t;
      rq.push_back('{e, m, r});
      @(posedge clock_in);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(negedge clock_in);
         t = s_axi_arvalid && s_axi_arready;
         @(posedge clock_in);
         if (t)
            s_axi_arvalid <= 1'b0;
      end while (!t);
      do
      begin
         @(negedge clock_in);
         t = s_axi_rvalid;
         @(posedge clock_in);
      end while (!t);
      s_axi_rready <= 1'b0;
   endtask

   // least significant byte first, fifth byte holds bit 32
   task automatic set_nom(logic [32:0] s);
      logic [39:0] x;
      x = {7'h0, s};
      for (int i = 0; i < 5; i++)
         wr(OFF_NOM_0 + 8'(4 * i), x[8 * i +: 8]);
   endtask

   task automatic wrap_up();
      if (err_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      logic [32:0] s;
      logic [7:0]  rv [5];
      int          e0;
      rv = '{8'h16, 8'h8A, 8'h2E, 8'hBA, 8'h00};
      void'($urandom(32'h1FA3));
      repeat (10) @(posedge clock_in);
      rst_in <= 1'b0;
      for (int i = 0; i < 5; i++)
         rd(OFF_NOM_0 + 8'(4 * i), {24'h0, rv[i]});  // default step bytes
      rd(OFF_STEP_LO, 32'hBA2E8A16);                  // default working step
      rd(OFF_STEP_HI, 32'h0);                         // top bit of working step
      rd(OFF_LINE_LO, 32'h20);                        // default line length low
      rd(OFF_LINE_HI, 32'h05);                        // default line length high
      rd(OFF_VCO_CODE, 32'h3);                        // default multiplier eight
      rd(OFF_OUT_CODE, 32'h1);                        // default divider two
      rd(8'h38, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
      wr(8'h38, 8'h5A, RESP_SLVERR);
      // random steps kept within 16..32, every code pair that stays legal
      for (int v = 0; v < 4; v++)
         for (int o = 0; o < 4; o++)
         begin
            if (o == 0 && v > 0)
               continue;
            s = {6'($urandom_range(16, 31)), 27'($urandom())};
            set_nom(s);                               // in-range step
            wr(OFF_VCO_CODE, 8'(v));
            wr(OFF_OUT_CODE, 8'(o));
            rd(OFF_STEP_LO, s[31:0]);                 // reload of step
            rd(OFF_STEP_HI, {31'h0, s[32]});          // top bit reload
            repeat (128) @(posedge clock_in);
            // divide by one: back-to-back tick pulses merge, so count high cycles
            e0 = (o == 0) ? out_highs : out_edges;
            repeat (2048) @(posedge clock_in);
            near("out_edges", 64.0 * (2.0 ** (32 + v)) / real'(s) / (2.0 ** o), // rate
               ((o == 0) ? out_highs : out_edges) - e0);
         end
      // step of exactly 32 gives four output periods per reference period
      set_nom(33'h100000000);
      wr(OFF_VCO_CODE, 8'h03);
      wr(OFF_OUT_CODE, 8'h01);                        // divider suits output range
      wr(OFF_LINE_HI, 8'hFF);
      rd(OFF_LINE_HI, 32'h0F);                        // only upper line bits kept
      wr(OFF_LINE_HI, 8'h00);
      wr(OFF_LINE_LO, 8'h40);                         // sixty-four outputs a line
      hs_per <= 16'd512;
      hs_en <= 1'b1;
      wr(OFF_CTRL, 8'h01);
      repeat (2048) @(posedge clock_in);
      rd(OFF_MEASURED, 32'd64);                       // count matches line length
      rd(OFF_STATUS, 32'h1);                          // lock reported
      @(negedge clock_in);
      cmp("locked_out", 32'h1, {31'h0, locked_out}); // lock pin
      hs_per <= 16'd768;
      repeat (2304) @(posedge clock_in);
      wr(OFF_CTRL, 8'h00);
      rd(OFF_MEASURED, 32'd96);                       // longer line measured
      rd(OFF_STEP_HI, 32'h1);                         // step stays above 32
      rd(OFF_STEP_LO, 32'h0, 32'h0);
      cmp("step_trim_grain", 32'h0, rd_last & 32'h00000FFF);  // trims in whole gain units
      cmp("step_trimmed", 32'h1, {31'h0, rd_last != 32'h0}); // step raised for long line
      wr(OFF_NOM_0, 8'h00);
      rd(OFF_STEP_LO, 32'h0);                         // nominal write restores step
      rd(OFF_STATUS, 32'h0);                          // lock cleared
      s_axi_wstrb <= 4'h0;
      wr(OFF_VCO_CODE, 8'h00);
      rd(OFF_VCO_CODE, 32'h3);                        // code kept when lane 0 strobe off
      wrap_up();
   end
endmodule // tb_top

`default_nettype wire
